// ### pkg/exec_pkg.sv
/*
  Constants for the nibble-swap / exclusive-OR / direction-load datapath:
  register offsets, field positions, reset values and operation codes.
  Assumes a 32-bit classic Wishbone slave with 12-bit byte addresses.
*/
`default_nettype none

package exec_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_INSTR = 12'h000;
  localparam logic [11:0] OFS_WORK = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_DIR = 12'h00C;
  localparam logic [11:0] OFS_RESULT = 12'h010;
  localparam logic [11:0] OFS_FILE_BASE = 12'h200;

  // Instruction word fields
  localparam int unsigned INSTR_LIT_LSB = 0;
  localparam int unsigned INSTR_FADDR_LSB = 8;
  localparam int unsigned INSTR_DEST_BIT = 16;
  localparam int unsigned INSTR_OP_LSB = 24;

  // Status fields
  localparam int unsigned STATUS_ZERO_BIT = 0;
  localparam int unsigned STATUS_BADDIR_BIT = 1;

  // Direction register lanes
  localparam int unsigned DIR_A_LSB = 0;
  localparam int unsigned DIR_B_LSB = 8;
  localparam int unsigned DIR_C_LSB = 16;

  // Result register fields
  localparam int unsigned RESULT_TGT_LSB = 8;

  // Operation codes
  localparam logic [1:0] OPC_NIBBLE_SWAP = 2'h0;
  localparam logic [1:0] OPC_XOR_LITERAL = 2'h1;
  localparam logic [1:0] OPC_XOR_FILE = 2'h2;
  localparam logic [1:0] OPC_DIRECTION_LOAD = 2'h3;

  // Direction-load operand values
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;

  // Write targets reported in the result register
  localparam logic [1:0] TGT_WORK = 2'h0;
  localparam logic [1:0] TGT_FILE = 2'h1;
  localparam logic [1:0] TGT_DIR = 2'h2;
  localparam logic [1:0] TGT_NONE = 2'h3;

  // Reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;

endpackage : exec_pkg

`default_nettype wire

// ### pkg/exec_if.sv
/*
  Interface between the register core and the execution datapath.
  Assumes both ends sit on the same clock; the datapath is combinational.
*/
`timescale 1ns/10ps
`default_nettype none

interface exec_if;
  // Decoded instruction and operands
  logic [1:0] op;
  logic dest;
  logic [7:0] literal;
  logic [6:0] faddr;
  logic [7:0] w_val;
  logic [7:0] f_val;
  // Outcome
  logic [7:0] result;
  logic wr_work;
  logic wr_file;
  logic wr_dir;
  logic [1:0] dir_idx;
  logic zero_upd;
  logic zero_val;
  logic bad_dir;

  modport alu (
    input op, dest, literal, faddr, w_val, f_val,
    output result, wr_work, wr_file, wr_dir, dir_idx, zero_upd, zero_val,
    output bad_dir
  );
  modport core (
    output op, dest, literal, faddr, w_val, f_val,
    input result, wr_work, wr_file, wr_dir, dir_idx, zero_upd, zero_val,
    input bad_dir
  );
endinterface : exec_if

`default_nettype wire

// ### verilog/exec_alu.sv
/*
  Combinational execution datapath for the four operations.
  Assumes the core supplies operands and applies the writes it reports.
*/
`timescale 1ns/10ps
`default_nettype none

module exec_alu (
  // Operands in, outcome out
  exec_if.alu x
);

  // Result, write targets and flag update per operation
  always_comb begin
    x.result = 8'h00;
    x.wr_work = 1'b0;
    x.wr_file = 1'b0;
    x.wr_dir = 1'b0;
    x.dir_idx = 2'h0;
    x.zero_upd = 1'b0;
    x.bad_dir = 1'b0;
    case (x.op)
      exec_pkg::OPC_NIBBLE_SWAP: begin
        x.result = {x.f_val[3:0], x.f_val[7:4]}; // RL1
        x.wr_work = ~x.dest; // RL2
        x.wr_file = x.dest; // RL2
      end
      exec_pkg::OPC_XOR_LITERAL: begin
        x.result = x.w_val ^ x.literal; // RL3
        x.wr_work = 1'b1; // RL3
        x.zero_upd = 1'b1; // RL3
      end
      exec_pkg::OPC_XOR_FILE: begin
        x.result = x.w_val ^ x.f_val; // RL4
        x.wr_work = ~x.dest; // RL4
        x.wr_file = x.dest; // RL4
        x.zero_upd = 1'b1; // RL4
      end
      exec_pkg::OPC_DIRECTION_LOAD: begin
        x.result = x.w_val; // RL5
        // Only the three defined operand values load a register
        if (x.faddr == exec_pkg::DIR_SEL_A) begin
          x.wr_dir = 1'b1; // RL6
          x.dir_idx = 2'h0;
        end else if (x.faddr == exec_pkg::DIR_SEL_B) begin
          x.wr_dir = 1'b1; // RL6
          x.dir_idx = 2'h1;
        end else if (x.faddr == exec_pkg::DIR_SEL_C) begin
          x.wr_dir = 1'b1; // RL6
          x.dir_idx = 2'h2;
        end else begin
          x.bad_dir = 1'b1; // RL6
        end
      end
      default: begin
        x.result = 8'h00;
      end
    endcase
  end

  // Zero flag value for operations that update it
  assign x.zero_val = (x.result == 8'h00); // RL7

endmodule // exec_alu

`default_nettype wire

// ### verilog/nibble_swap_xor_direction_load_op_exec.sv
/*
  Register core of the nibble-swap / exclusive-OR / direction-load
  datapath, reached over a 32-bit classic Wishbone slave.
  Assumes one clock, a synchronous active-high reset and a master that
  holds its request until it sees ack.
*/
//
// Notes on behaviour
// RL1: Swap places low nibble high, high nibble low.
// RL2: Swap result to work when dest 0, else file.
// RL3: Literal XOR writes work, updates only zero.
// RL4: File XOR updates zero, dest picks target.
// RL5: Direction load copies work, zero flag untouched.
// RL6: Operand 5,6,7 selects port A, B, C.
// RL7: Zero flag set exactly when result is zero.
`timescale 1ns/10ps
`default_nettype none

module nibble_swap_xor_direction_load_op_exec #(
  parameter int unsigned FILE_DEPTH = 128
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port direction registers
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  // One-cycle pulse after each executed instruction
  output logic exec_done
);

  localparam int unsigned IDX_W = $clog2(FILE_DEPTH);

  exec_if ex ();

  logic ack_r;
  logic [31:0] rdat_r;
  logic [7:0] work_r;
  logic zero_r;
  logic bad_dir_r;
  logic [7:0] dir_r [3];
  logic [7:0] file_r [FILE_DEPTH];
  logic [7:0] result_r;
  logic [1:0] target_r;
  logic done_r;

  logic access;
  logic commit;
  logic wr_commit;
  logic is_file;
  logic [IDX_W-1:0] bus_idx;
  logic [IDX_W-1:0] exec_idx;
  logic exec_go;
  logic [31:0] read_nxt;

  // Bus phase decoding: ack one cycle after the request is seen
  assign access = wb_cyc_i & wb_stb_i;
  assign commit = access & ack_r;
  assign wr_commit = commit & wb_we_i;
  assign is_file = (wb_adr_i[11:9] == exec_pkg::OFS_FILE_BASE[11:9]) &&
                   (32'(wb_adr_i[8:2]) < FILE_DEPTH);
  assign bus_idx = wb_adr_i[IDX_W+1:2];

  // An instruction executes on a full-word write to the instruction word
  assign exec_go = wr_commit && (wb_adr_i == exec_pkg::OFS_INSTR) &&
                   (wb_sel_i == 4'hF);

  // Operands for the datapath come straight from the held write data
  assign ex.op = wb_dat_i[exec_pkg::INSTR_OP_LSB +: 2];
  assign ex.dest = wb_dat_i[exec_pkg::INSTR_DEST_BIT];
  assign ex.literal = wb_dat_i[exec_pkg::INSTR_LIT_LSB +: 8];
  assign ex.faddr = wb_dat_i[exec_pkg::INSTR_FADDR_LSB +: 7];
  assign ex.w_val = work_r;
  assign exec_idx = ex.faddr[IDX_W-1:0];
  assign ex.f_val = file_r[exec_idx];

  exec_alu u_alu (
    .x(ex)
  );

  // Acknowledge handshake
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access & ~ack_r;
    end
  end

  // Read data multiplexer, unmapped addresses read as zero
  always_comb begin
    read_nxt = 32'h00000000;
    if (is_file) begin
      read_nxt[7:0] = file_r[bus_idx];
    end else begin
      case (wb_adr_i)
        exec_pkg::OFS_WORK: read_nxt[7:0] = work_r;
        exec_pkg::OFS_STATUS: begin
          read_nxt[exec_pkg::STATUS_ZERO_BIT] = zero_r;
          read_nxt[exec_pkg::STATUS_BADDIR_BIT] = bad_dir_r;
        end
        exec_pkg::OFS_DIR: begin
          read_nxt[exec_pkg::DIR_A_LSB +: 8] = dir_r[0];
          read_nxt[exec_pkg::DIR_B_LSB +: 8] = dir_r[1];
          read_nxt[exec_pkg::DIR_C_LSB +: 8] = dir_r[2];
        end
        exec_pkg::OFS_RESULT: begin
          read_nxt[7:0] = result_r;
          read_nxt[exec_pkg::RESULT_TGT_LSB +: 2] = target_r;
        end
        default: read_nxt = 32'h00000000;
      endcase
    end
  end

  // Read data captured with the acknowledge
  always_ff @(posedge clock) begin
    if (srst) begin
      rdat_r <= 32'h00000000;
    end else if (access & ~ack_r & ~wb_we_i) begin
      rdat_r <= read_nxt;
    end
  end

  // Working register: software byte 0 or an executed operation
  always_ff @(posedge clock) begin
    if (srst) begin
      work_r <= exec_pkg::WORK_RST;
    end else if (exec_go && ex.wr_work) begin
      work_r <= ex.result; // RL2 RL3 RL4
    end else if (wr_commit && wb_adr_i == exec_pkg::OFS_WORK &&
                 wb_sel_i[0]) begin
      work_r <= wb_dat_i[7:0];
    end
  end

  // File registers: software access or result written back
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_r[i] <= exec_pkg::FILE_RST;
      end
    end else if (exec_go && ex.wr_file) begin
      file_r[exec_idx] <= ex.result; // RL2 RL4
    end else if (wr_commit && is_file && wb_sel_i[0]) begin
      file_r[bus_idx] <= wb_dat_i[7:0];
    end
  end

  // Zero flag: only the exclusive-OR operations or a software status write touch it
  always_ff @(posedge clock) begin
    if (srst) begin
      zero_r <= 1'b0;
    end else if (exec_go && ex.zero_upd) begin
      zero_r <= ex.zero_val; // RL3 RL4 RL7
    end else if (wr_commit && wb_adr_i == exec_pkg::OFS_STATUS &&
                 wb_sel_i[0]) begin
      zero_r <= wb_dat_i[exec_pkg::STATUS_ZERO_BIT];
    end
  end

  // Invalid direction operand: sticky, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (srst) begin
      bad_dir_r <= 1'b0;
    end else if (exec_go && ex.bad_dir) begin
      bad_dir_r <= 1'b1; // RL6
    end else if (wr_commit && wb_adr_i == exec_pkg::OFS_STATUS &&
                 wb_sel_i[0] && wb_dat_i[exec_pkg::STATUS_BADDIR_BIT]) begin
      bad_dir_r <= 1'b0;
    end
  end

  // Port direction registers, loaded only by the direction operation
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < 3; i++) begin
        dir_r[i] <= exec_pkg::DIR_RST;
      end
    end else if (exec_go && ex.wr_dir) begin
      dir_r[ex.dir_idx] <= ex.result; // RL5 RL6
    end
  end

  // Last result and where it went
  always_ff @(posedge clock) begin
    if (srst) begin
      result_r <= 8'h00;
      target_r <= exec_pkg::TGT_NONE;
    end else if (exec_go) begin
      result_r <= ex.result;
      if (ex.wr_work) begin
        target_r <= exec_pkg::TGT_WORK;
      end else if (ex.wr_file) begin
        target_r <= exec_pkg::TGT_FILE;
      end else if (ex.wr_dir) begin
        target_r <= exec_pkg::TGT_DIR;
      end else begin
        target_r <= exec_pkg::TGT_NONE;
      end
    end
  end

  // Completion pulse
  always_ff @(posedge clock) begin
    if (srst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= exec_go;
    end
  end

  // Outputs
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign port_a_direction = dir_r[0];
  assign port_b_direction = dir_r[1];
  assign port_c_direction = dir_r[2];
  assign exec_done = done_r;

endmodule // nibble_swap_xor_direction_load_op_exec

`default_nettype wire

// ### sim/nibble_swap_xor_direction_load_op_exec_assertions.sv
/* Checker: direction outputs and completion pulse against
   instruction writes. Bound to the top module below. */
`timescale 1ns/10ps
`default_nettype none
module nibble_swap_xor_direction_load_op_exec_assertions #(
  parameter int unsigned FILE_DEPTH = 128
) (
  // Clock, reset and bus
  input wire logic clock,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Outputs
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] port_b_direction,
  input wire logic [7:0] port_c_direction,
  input wire logic exec_done
);
  logic go;
  logic ld;
  logic [6:0] fa;
  // Instruction commit decode
  assign go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_sel_i == 4'hF)
    & (wb_adr_i == exec_pkg::OFS_INSTR);
  assign ld = go & (wb_dat_i[25:24] == exec_pkg::OPC_DIRECTION_LOAD);
  assign fa = wb_dat_i[14:8];
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_load_a;
    ld && fa == exec_pkg::DIR_SEL_A |=> $stable(port_b_direction)
      && $stable(port_c_direction);
  endproperty
  a_load_a: assert property (p_load_a) else $error("a load moved b or c");
  property p_load_b;
    ld && fa == exec_pkg::DIR_SEL_B |=> $stable(port_a_direction)
      && $stable(port_c_direction);
  endproperty
  a_load_b: assert property (p_load_b) else $error("b load moved a or c");
  property p_load_c;
    ld && fa == exec_pkg::DIR_SEL_C |=> $stable(port_a_direction)
      && $stable(port_b_direction);
  endproperty
  a_load_c: assert property (p_load_c) else $error("c load moved a or b");
  property p_load_bad;
    ld && (fa < 7'h05 || fa > 7'h07) |=> $stable({port_a_direction,
      port_b_direction, port_c_direction});
  endproperty
  a_load_bad: assert property (p_load_bad) else $error("bad load moved");
  property p_no_load;
    !ld |=> $stable({port_a_direction, port_b_direction, port_c_direction});
  endproperty
  a_no_load: assert property (p_no_load) else $error("direction moved");
  property p_done;
    go |=> exec_done ##1 !exec_done;
  endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_done_cause;
    exec_done |-> $past(go);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("stray done");
endmodule // nibble_swap_xor_direction_load_op_exec_assertions
bind nibble_swap_xor_direction_load_op_exec nibble_swap_xor_direction_load_op_exec_assertions #(
  .FILE_DEPTH(FILE_DEPTH)
) u_chk (.clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .port_a_direction(port_a_direction),
  .port_b_direction(port_b_direction),
  .port_c_direction(port_c_direction), .exec_done(exec_done));
`default_nettype wire

// ### sim/nibble_swap_xor_direction_load_op_exec_test.sv
/* Table-driven bench for the execution block over classic Wishbone.
   Assumes the register map and reset values of the package. */
`timescale 1ns/10ps
`default_nettype none
module nibble_swap_xor_direction_load_op_exec_test;
  typedef struct packed {
    logic [1:0] op;
    logic [6:0] fa;
    logic d, zp, ez;
    logic [7:0] lit, w, f, ew, ef;
    logic [23:0] dir;
  } row_s;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o, q;
  logic ack, done;
  logic [7:0] pa, pb, pc;
  int fail_count = 0;
  int n_compared = 0;
  row_s r;
  logic bad;
  logic bad_seen = 1'b0;
  logic [7:0] res;
  logic [1:0] tgt;
  // Op, addr, dest, zero preset, zero, literal, work, file, results, dir
  row_s rows [11] = '{
    '{2'h0, 7'h03, 1'h0, 1'h1, 1'h1, 8'h00, 8'h12, 8'hA5, 8'h5A, 8'hA5,
      24'hFFFFFF},
    '{2'h0, 7'h7F, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 8'h3C, 8'h00, 8'hC3,
      24'hFFFFFF},
    '{2'h0, 7'h00, 1'h0, 1'h0, 1'h0, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
      24'hFFFFFF},
    '{2'h1, 7'h04, 1'h0, 1'h1, 1'h0, 8'h0F, 8'hF0, 8'h77, 8'hFF, 8'h77,
      24'hFFFFFF},
    '{2'h1, 7'h04, 1'h1, 1'h0, 1'h1, 8'hAA, 8'hAA, 8'h77, 8'h00, 8'h77,
      24'hFFFFFF},
    '{2'h2, 7'h10, 1'h0, 1'h0, 1'h1, 8'h00, 8'h55, 8'h55, 8'h00, 8'h55,
      24'hFFFFFF},
    '{2'h2, 7'h7F, 1'h1, 1'h1, 1'h0, 8'hFF, 8'h0F, 8'hF1, 8'h0F, 8'hFE,
      24'hFFFFFF},
    '{2'h3, 7'h05, 1'h0, 1'h1, 1'h1, 8'h00, 8'h11, 8'h00, 8'h11, 8'h00,
      24'hFFFF11},
    '{2'h3, 7'h06, 1'h0, 1'h0, 1'h0, 8'h00, 8'h22, 8'h00, 8'h22, 8'h00,
      24'hFF2211},
    '{2'h3, 7'h07, 1'h1, 1'h1, 1'h1, 8'h00, 8'h33, 8'h00, 8'h33, 8'h00,
      24'h332211},
    '{2'h3, 7'h04, 1'h0, 1'h0, 1'h0, 8'h00, 8'h44, 8'h00, 8'h44, 8'h00,
      24'h332211}};
  // Clock
  always #50 clock = ~clock;
  nibble_swap_xor_direction_load_op_exec dut (.clock(clock), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc),
    .exec_done(done));
  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    foreach (rows[i]) begin
      r = rows[i];
      // Invalid direction operand expected, sticky until cleared
      bad = (r.op == exec_pkg::OPC_DIRECTION_LOAD) &&
        (r.fa < exec_pkg::DIR_SEL_A || r.fa > exec_pkg::DIR_SEL_C);
      bad_seen = bad_seen | bad;
      // Expected last result and where it went
      if (r.op == exec_pkg::OPC_DIRECTION_LOAD) begin
        res = r.w;
        tgt = bad ? exec_pkg::TGT_NONE : exec_pkg::TGT_DIR;
      end else if (r.op != exec_pkg::OPC_XOR_LITERAL && r.d) begin
        res = r.ef;
        tgt = exec_pkg::TGT_FILE;
      end else begin
        res = r.ew;
        tgt = exec_pkg::TGT_WORK;
      end
      wb(1'b1, exec_pkg::OFS_WORK, {24'h000000, r.w}, 4'hF, q);
      wb(1'b1, exec_pkg::OFS_FILE_BASE | {3'h0, r.fa, 2'h0},
        {24'h000000, r.f}, 4'hF, q);
      wb(1'b1, exec_pkg::OFS_STATUS, {31'h00000000, r.zp}, 4'hF, q);
      wb(1'b1, exec_pkg::OFS_INSTR, {6'h00, r.op, 7'h00, r.d, 1'h0, r.fa,
        r.lit}, 4'hF, q);
      chk("done", {31'h00000000, done}, 32'h00000001);
      wb(1'b0, exec_pkg::OFS_WORK, 32'h00000000, 4'hF, q);
      chk("work", q, {24'h000000, r.ew});
      wb(1'b0, exec_pkg::OFS_FILE_BASE | {3'h0, r.fa, 2'h0}, 32'h00000000,
        4'hF, q);
      chk("file", q, {24'h000000, r.ef});
      wb(1'b0, exec_pkg::OFS_STATUS, 32'h00000000, 4'hF, q);
      chk("zero", {31'h00000000, q[0]}, {31'h00000000, r.ez});
      chk("bad_dir", {31'h00000000, q[1]}, {31'h00000000, bad_seen});
      wb(1'b0, exec_pkg::OFS_DIR, 32'h00000000, 4'hF, q);
      chk("dir", q, {8'h00, r.dir});
      wb(1'b0, exec_pkg::OFS_RESULT, 32'h00000000, 4'hF, q);
      chk("result", q, {22'h000000, tgt, res});
    end
    chk("dir_pins", {8'h00, pc, pb, pa}, 32'h00332211);
    wb(1'b0, exec_pkg::OFS_STATUS, 32'h00000000, 4'hF, q);
    chk("bad_dir", {31'h00000000, q[1]}, 32'h00000001);
    // Writing one to the flag clears it
    wb(1'b1, exec_pkg::OFS_STATUS, 32'h00000002, 4'hF, q);
    wb(1'b0, exec_pkg::OFS_STATUS, 32'h00000000, 4'hF, q);
    chk("bad_dir_clr", {31'h00000000, q[1]}, 32'h00000000);
    // Partial instruction write must not execute
    wb(1'b1, exec_pkg::OFS_INSTR, 32'h010000F0, 4'h1, q);
    chk("done_sel", {31'h00000000, done}, 32'h00000000);
    wb(1'b0, exec_pkg::OFS_WORK, 32'h00000000, 4'hF, q);
    chk("work_sel", q, 32'h00000044);
    wb(1'b0, 12'h100, 32'h00000000, 4'hF, q);
    chk("unmapped", q, 32'h00000000);
    // Second reset in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    chk("dir_rst", {8'h00, pc, pb, pa}, 32'h00FFFFFF);
    wb(1'b0, exec_pkg::OFS_WORK, 32'h00000000, 4'hF, q);
    chk("work_rst", q, 32'h00000000);
    finish_test();
  end
endmodule // nibble_swap_xor_direction_load_op_exec_test
`default_nettype wire
